//--- logic/ppl_loader.v
// Passive parallel configuration loader: device side of the load port.
// Assumes a host drives request, image clock and data pins asynchronously,
// and that status and completion lines are open-drain with pull-ups outside.
//
// Contract
// - Byte width: ratio 1, or 2 compressed
// - Word width: ratio 1, 2 encrypted, 4 compressed
// - Request low pulls both lines low quickly
// - Status low between 268 and 1506 us
// - Status released within 1506 us after request
// - External status hold postpones the load
// - Data word captured on rising image clock
// - User mode 175 to 437 us later
// - Initialization needs 8576 init clock cycles
// - Power-on delay fast or standard range
`timescale 1ns/1ps
`default_nettype none
`include "ppl_defs.vh"

module ppl_loader #(
	parameter P_CNT_W = 26,
	parameter [P_CNT_W-1:0] P_POR_FAST_CYC = `PPL_POR_FAST_CYC,
	parameter [P_CNT_W-1:0] P_POR_STD_CYC = `PPL_POR_STD_CYC,
	parameter [P_CNT_W-1:0] P_STATUS_MIN_CYC = `PPL_STATUS_MIN_CYC,
	parameter [P_CNT_W-1:0] P_INIT_OSC_CYC = `PPL_INIT_OSC_CYC,
	parameter [P_CNT_W-1:0] P_INIT_USER_CYC = `PPL_INIT_USER_CYCLES,
	parameter P_DATA_W = 16
) (
	input wire i_clock,
	input wire i_rst,
	// Register port
	input wire [`PPL_ADDR_W-1:0] i_addr,
	input wire [31:0] i_wr_data,
	input wire i_wr,
	input wire i_rd,
	output wire [31:0] o_rd_data,
	// Load pins
	input wire i_reconfig_request_n,
	input wire i_image_clock,
	input wire [P_DATA_W-1:0] i_image_data,
	input wire i_user_init_clock,
	input wire i_load_status_n,
	output wire o_load_status_n,
	output wire o_load_status_n_oe_n,
	input wire i_load_complete,
	output wire o_load_complete,
	output wire o_load_complete_oe_n,
	// Word stream to the configuration core
	output wire o_word_valid,
	input wire i_word_ready,
	output wire [P_DATA_W-1:0] o_word_data,
	output wire o_user_mode
);

	localparam [`PPL_ST_W-1:0] S_POR = 7'h01;
	localparam [`PPL_ST_W-1:0] S_HOLD = 7'h02;
	localparam [`PPL_ST_W-1:0] S_RELEASE = 7'h04;
	localparam [`PPL_ST_W-1:0] S_RECEIVE = 7'h08;
	localparam [`PPL_ST_W-1:0] S_INIT = 7'h10;
	localparam [`PPL_ST_W-1:0] S_USER = 7'h20;
	localparam [`PPL_ST_W-1:0] S_ERROR = 7'h40;
	localparam SYNC_W = P_DATA_W + 4;
	localparam [P_CNT_W-1:0] CNT_ONE = {{(P_CNT_W-1){1'b0}}, 1'b1};

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	wire [SYNC_W-1:0] sync_q;
	wire req_s;
	wire img_clk_s;
	wire usr_clk_s;
	wire status_s;
	wire [P_DATA_W-1:0] data_s;
	wire unused_complete;

	ppl_sync #(
		.W(SYNC_W)
	) u_sync (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_d({i_reconfig_request_n, i_image_clock, i_user_init_clock, i_load_status_n,
			i_image_data}),
		.o_q(sync_q)
	);

	assign req_s = sync_q[SYNC_W-1];
	assign img_clk_s = sync_q[SYNC_W-2];
	assign usr_clk_s = sync_q[SYNC_W-3];
	assign status_s = sync_q[SYNC_W-4];
	assign data_s = sync_q[P_DATA_W-1:0];
	// Own completion drive is the only one on this net in practice
	assign unused_complete = i_load_complete;

	reg img_clk_d_reg;
	reg usr_clk_d_reg;
	reg [P_DATA_W-1:0] data_d_reg;
	wire img_rise;
	wire usr_rise;

	// Data sampled one core cycle before the edge is seen: setup exceeds
	// a core period, while hold may be zero at ratio one.
	always @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			img_clk_d_reg <= 1'b0;
			usr_clk_d_reg <= 1'b0;
			data_d_reg <= {P_DATA_W{1'b0}};
		end else begin
			img_clk_d_reg <= img_clk_s;
			usr_clk_d_reg <= usr_clk_s;
			data_d_reg <= data_s;
		end
	end

	assign img_rise = img_clk_s & ~img_clk_d_reg;
	assign usr_rise = usr_clk_s & ~usr_clk_d_reg;

	////////////////////////////////////////////////////////////////////////
	// Registers

	reg [`PPL_CTRL_W-1:0] ctrl_reg;
	reg [31:0] len_reg;
	reg [31:0] rd_data_reg;
	reg [31:0] word_cnt_reg;
	reg overflow_reg;
	reg user_mode_reg;
	reg [`PPL_ST_W-1:0] state_reg;
	reg [2:0] ratio;
	wire [31:0] status_word;

	always @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ctrl_reg <= `PPL_CTRL_RST;
			len_reg <= `PPL_LEN_RST;
		end else if (i_wr) begin
			if (i_addr == `PPL_REG_CTRL)
				ctrl_reg <= i_wr_data[`PPL_CTRL_W-1:0];
			if (i_addr == `PPL_REG_LEN)
				len_reg <= i_wr_data;
		end
	end

	assign status_word = {19'h0, user_mode_reg, status_s, overflow_reg, ratio, state_reg};

	always @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			rd_data_reg <= 32'h0;
		end else if (i_rd) begin
			case (i_addr)
			`PPL_REG_CTRL: rd_data_reg <= {{(32-`PPL_CTRL_W){1'b0}}, ctrl_reg};
			`PPL_REG_LEN: rd_data_reg <= len_reg;
			`PPL_REG_STATUS: rd_data_reg <= status_word;
			`PPL_REG_COUNT: rd_data_reg <= word_cnt_reg;
			default: rd_data_reg <= 32'h0;
			endcase
		end else begin
			rd_data_reg <= 32'h0;
		end
	end

	assign o_rd_data = rd_data_reg;

	////////////////////////////////////////////////////////////////////////
	// Clock-to-data ratio

	always @* begin
		if (ctrl_reg[`PPL_CTRL_WIDE16]) begin
			if (ctrl_reg[`PPL_CTRL_COMPRESS])
				ratio = `PPL_RATIO_4;
			else if (ctrl_reg[`PPL_CTRL_ENCRYPT])
				ratio = `PPL_RATIO_2;
			else
				ratio = `PPL_RATIO_1;
		end else begin
			if (ctrl_reg[`PPL_CTRL_COMPRESS])
				ratio = `PPL_RATIO_2;
			else
				ratio = `PPL_RATIO_1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Capture and buffer

	reg [2:0] phase_reg;
	wire capture;
	wire last_word;
	wire buf_ready;
	wire [P_DATA_W-1:0] cap_word;
	wire flush;

	// Only the first edge of each ratio group takes a word; the
	// remaining edges feed decryption or decompression time.
	assign capture = state_reg[3] & img_rise & (phase_reg == 3'h0);
	assign last_word = (word_cnt_reg + 32'h1) == len_reg;
	assign cap_word = ctrl_reg[`PPL_CTRL_WIDE16] ? data_d_reg :
		{{(P_DATA_W-8){1'b0}}, data_d_reg[7:0]};
	assign flush = ~req_s;

	always @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			phase_reg <= 3'h0;
		end else if (!state_reg[3]) begin
			phase_reg <= 3'h0;
		end else if (img_rise) begin
			if (phase_reg + 3'h1 == ratio)
				phase_reg <= 3'h0;
			else
				phase_reg <= phase_reg + 3'h1;
		end
	end

	ppl_buf #(
		.W(P_DATA_W)
	) u_buf (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_flush(flush),
		.i_in_valid(capture),
		.o_in_ready(buf_ready),
		.i_in_data(cap_word),
		.o_out_valid(o_word_valid),
		.i_out_ready(i_word_ready),
		.o_out_data(o_word_data)
	);

	////////////////////////////////////////////////////////////////////////
	// Sequencer

	reg [`PPL_ST_W-1:0] state_next;
	reg [P_CNT_W-1:0] cnt_reg;
	reg [P_CNT_W-1:0] cnt_next;
	reg [P_CNT_W-1:0] por_target;
	reg status_oe_n_reg;
	reg complete_oe_n_reg;
	reg drive_low_reg;

	always @* begin
		if (ctrl_reg[`PPL_CTRL_FAST_POR])
			por_target = P_POR_FAST_CYC;
		else
			por_target = P_POR_STD_CYC;
	end

	always @* begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		case (state_reg)
		S_POR: begin
			cnt_next = cnt_reg + CNT_ONE;
			if (cnt_reg >= por_target) begin
				state_next = S_HOLD;
				cnt_next = {P_CNT_W{1'b0}};
			end
		end
		S_HOLD: begin
			if (cnt_reg < P_STATUS_MIN_CYC)
				cnt_next = cnt_reg + CNT_ONE;
			else if (req_s)
				state_next = S_RELEASE;
		end
		S_RELEASE: begin
			// Line held low outside postpones the load
			if (status_s)
				state_next = S_RECEIVE;
		end
		S_RECEIVE: begin
			if (capture && !buf_ready)
				state_next = S_ERROR;
			else if (capture && last_word) begin
				state_next = S_INIT;
				cnt_next = {P_CNT_W{1'b0}};
			end
		end
		S_INIT: begin
			if (ctrl_reg[`PPL_CTRL_USER_CLK]) begin
				if (usr_rise)
					cnt_next = cnt_reg + CNT_ONE;
				if (cnt_reg >= P_INIT_USER_CYC)
					state_next = S_USER;
			end else begin
				cnt_next = cnt_reg + CNT_ONE;
				if (cnt_reg >= P_INIT_OSC_CYC)
					state_next = S_USER;
			end
		end
		S_USER: begin
			state_next = S_USER;
		end
		S_ERROR: begin
			state_next = S_ERROR;
		end
		default: begin
			state_next = S_HOLD;
			cnt_next = {P_CNT_W{1'b0}};
		end
		endcase
		// A new request restarts from any state but power-on
		if (!req_s && !state_reg[0]) begin
			state_next = S_HOLD;
			if (!state_reg[1])
				cnt_next = {P_CNT_W{1'b0}};
		end
	end

	always @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= S_POR;
			cnt_reg <= {P_CNT_W{1'b0}};
			status_oe_n_reg <= 1'b0;
			complete_oe_n_reg <= 1'b0;
			drive_low_reg <= 1'b0;
			user_mode_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			// Status line low in power-on, hold and error
			status_oe_n_reg <= ~(state_next[0] | state_next[1] | state_next[6]);
			// Completion line low until the whole image is in
			complete_oe_n_reg <= state_next[4] | state_next[5];
			drive_low_reg <= 1'b0;
			user_mode_reg <= state_next[5];
		end
	end

	assign o_load_status_n = drive_low_reg;
	assign o_load_status_n_oe_n = status_oe_n_reg;
	assign o_load_complete = drive_low_reg;
	assign o_load_complete_oe_n = complete_oe_n_reg;
	assign o_user_mode = user_mode_reg;

	////////////////////////////////////////////////////////////////////////
	// Word count and overflow

	always @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			word_cnt_reg <= 32'h0;
			overflow_reg <= 1'b0;
		end else if (!req_s) begin
			word_cnt_reg <= 32'h0;
			overflow_reg <= 1'b0;
		end else if (capture) begin
			// Host cannot be stalled, so a full buffer is a load error
			if (!buf_ready)
				overflow_reg <= 1'b1;
			else
				word_cnt_reg <= word_cnt_reg + 32'h1;
		end
	end

endmodule // ppl_loader

`default_nettype wire

//--- logic/ppl_defs.vh
// Constants for the passive parallel configuration loader.
// Assumes a 250 MHz core clock; times are kept in their own units.
`ifndef PPL_DEFS_VH
`define PPL_DEFS_VH

`define PPL_CLK_NS 4
`define PPL_POR_FAST_MIN_MS 4
`define PPL_POR_STD_MIN_MS 100
`define PPL_STATUS_MIN_US 268
`define PPL_INIT_OSC_MIN_US 175
`define PPL_INIT_USER_CYCLES 8576

`define PPL_CEIL_CYC(ns) (((ns) + `PPL_CLK_NS - 1) / `PPL_CLK_NS)
`define PPL_POR_FAST_CYC `PPL_CEIL_CYC(`PPL_POR_FAST_MIN_MS * 1000000)
`define PPL_POR_STD_CYC `PPL_CEIL_CYC(`PPL_POR_STD_MIN_MS * 1000000)
`define PPL_STATUS_MIN_CYC `PPL_CEIL_CYC(`PPL_STATUS_MIN_US * 1000)
`define PPL_INIT_OSC_CYC `PPL_CEIL_CYC(`PPL_INIT_OSC_MIN_US * 1000)

`define PPL_ADDR_W 4
`define PPL_REG_CTRL 4'h0
`define PPL_REG_LEN 4'h4
`define PPL_REG_STATUS 4'h8
`define PPL_REG_COUNT 4'hc

`define PPL_CTRL_W 5
`define PPL_CTRL_RST 5'h00
`define PPL_CTRL_WIDE16 0
`define PPL_CTRL_ENCRYPT 1
`define PPL_CTRL_COMPRESS 2
`define PPL_CTRL_USER_CLK 3
`define PPL_CTRL_FAST_POR 4
`define PPL_LEN_RST 32'h0000_0000

`define PPL_ST_W 7
`define PPL_STAT_RATIO_LSB 7
`define PPL_STAT_RATIO_MSB 9
`define PPL_STAT_OVERFLOW 10
`define PPL_STAT_LINE 11
`define PPL_STAT_USER 12

`define PPL_RATIO_1 3'h1
`define PPL_RATIO_2 3'h2
`define PPL_RATIO_4 3'h4

`endif

//--- logic/ppl_sync.v
// Two-flop synchroniser for a group of pin inputs.
// Assumes each bit is a level sampled on its own; no bus coherency.
`timescale 1ns/1ps
`default_nettype none

module ppl_sync #(
	parameter W = 20
) (
	input wire i_clock,
	input wire i_rst,
	input wire [W-1:0] i_d,
	output wire [W-1:0] o_q
);

	reg [W-1:0] meta_reg;
	reg [W-1:0] sync_reg;

	always @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			meta_reg <= {W{1'b0}};
			sync_reg <= {W{1'b0}};
		end else begin
			meta_reg <= i_d;
			sync_reg <= meta_reg;
		end
	end

	assign o_q = sync_reg;

endmodule // ppl_sync

`default_nettype wire

//--- logic/ppl_buf.v
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; outputs are registered, input ready comes straight from the second-entry valid register.
`timescale 1ns/1ps
`default_nettype none

module ppl_buf #(
	parameter W = 16
) (
	input wire i_clock,
	input wire i_rst,
	input wire i_flush,
	input wire i_in_valid,
	output wire o_in_ready,
	input wire [W-1:0] i_in_data,
	output wire o_out_valid,
	input wire i_out_ready,
	output wire [W-1:0] o_out_data
);

	reg out_valid_reg;
	reg [W-1:0] out_data_reg;
	reg skid_valid_reg;
	reg [W-1:0] skid_data_reg;
	wire push;

	assign o_in_ready = ~skid_valid_reg;
	assign push = i_in_valid & ~skid_valid_reg;

	always @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			out_valid_reg <= 1'b0;
			out_data_reg <= {W{1'b0}};
			skid_valid_reg <= 1'b0;
			skid_data_reg <= {W{1'b0}};
		end else if (i_flush) begin
			out_valid_reg <= 1'b0;
			skid_valid_reg <= 1'b0;
		end else if (!out_valid_reg || i_out_ready) begin
			if (skid_valid_reg) begin
				out_data_reg <= skid_data_reg;
				out_valid_reg <= 1'b1;
				skid_valid_reg <= 1'b0;
			end else begin
				out_data_reg <= i_in_data;
				out_valid_reg <= push;
			end
		end else if (push) begin
			// Output held by receiver: park word in second entry
			skid_data_reg <= i_in_data;
			skid_valid_reg <= 1'b1;
		end
	end

	assign o_out_valid = out_valid_reg;
	assign o_out_data = out_data_reg;

endmodule // ppl_buf

`default_nettype wire

//--- verification/ppl_loader_sva.sv
// Port checks for the configuration loader.
// Assumes it is bound into ppl_loader and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module ppl_loader_sva #(
	parameter P_STATUS_MIN_CYC = 16,
	parameter P_INIT_USER_CYC = 8,
	parameter P_DATA_W = 16
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_rd,
	input wire logic [31:0] o_rd_data,
	input wire logic i_reconfig_request_n,
	input wire logic o_load_status_n_oe_n,
	input wire logic o_load_complete_oe_n,
	input wire logic o_word_valid,
	input wire logic i_word_ready,
	input wire logic [P_DATA_W-1:0] o_word_data,
	input wire logic o_user_mode
);
	// Saturating run lengths of the low status and released completion
	logic [7:0] low_reg;
	logic [7:0] hi_reg;
	always @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			low_reg <= 8'h00;
			hi_reg <= 8'h00;
		end else begin
			low_reg <= o_load_status_n_oe_n ? 8'h00 : low_reg + {7'h00, ~&low_reg};
			hi_reg <= o_load_complete_oe_n ? hi_reg + {7'h00, ~&hi_reg} : 8'h00;
		end
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	pull_low_a: assert property ($fell(i_reconfig_request_n) |->
		##[1:150] (!o_load_status_n_oe_n && !o_load_complete_oe_n)) else $error("lines not low");
	status_min_a: assert property ($rose(o_load_status_n_oe_n) |->
		low_reg >= P_STATUS_MIN_CYC) else $error("status low too short");
	status_free_a: assert property ($rose(i_reconfig_request_n) |->
		##[1:40] o_load_status_n_oe_n) else $error("status not released");
	done_order_a: assert property ($rose(o_load_complete_oe_n) |->
		o_load_status_n_oe_n && !o_user_mode) else $error("completion out of order");
	init_min_a: assert property ($rose(o_user_mode) |->
		hi_reg >= P_INIT_USER_CYC) else $error("user mode too early");
	user_lines_a: assert property (o_user_mode |->
		o_load_status_n_oe_n && o_load_complete_oe_n) else $error("lines low in user mode");
	word_hold_a: assert property (o_word_valid && !i_word_ready |=>
		o_word_valid && $stable(o_word_data)) else $error("word lost in stall");
	rd_idle_a: assert property (!$past(i_rd) |-> o_rd_data == 32'h0) else $error("stray read data");
endmodule // ppl_loader_sva
bind ppl_loader ppl_loader_sva #(.P_STATUS_MIN_CYC(P_STATUS_MIN_CYC),
	.P_INIT_USER_CYC(P_INIT_USER_CYC), .P_DATA_W(P_DATA_W)) i_sva (.i_clock(i_clock),
	.i_rst(i_rst), .i_rd(i_rd), .o_rd_data(o_rd_data),
	.i_reconfig_request_n(i_reconfig_request_n), .o_load_status_n_oe_n(o_load_status_n_oe_n),
	.o_load_complete_oe_n(o_load_complete_oe_n), .o_word_valid(o_word_valid),
	.i_word_ready(i_word_ready), .o_word_data(o_word_data), .o_user_mode(o_user_mode));
`default_nettype wire

//--- verification/ppl_host.sv
// Behavioural configuration host on the load pins.
// Assumes resolved status and completion wire levels as inputs.
`timescale 1ns/1ps
`default_nettype none
module ppl_host (
	input wire logic i_load_status_n,
	input wire logic i_load_complete,
	output var logic o_reconfig_request_n,
	output var logic o_image_clock,
	output var logic [15:0] o_image_data,
	output var logic o_user_init_clock
);
	logic user_en;
	initial begin
		user_en = 1'b0;
		o_reconfig_request_n = 1'b1;
		o_image_clock = 1'b0;
		o_image_data = 16'h0000;
		o_user_init_clock = 1'b0;
	end
	task request;
		begin
			o_reconfig_request_n = 1'b0;
			#2000 o_reconfig_request_n = 1'b1;
		end
	endtask
	// Image clock stands still outside a frame
	task send(input integer n, input integer r, input [15:0] b);
		integer k;
		begin
			wait (i_load_status_n === 1'b1);
			// Odd offset keeps every pin change off the core clock edge
			#2001;
			for (k = 0; k < n; k = k + 1) begin
				o_image_data = b + k * 16'h1111;
				repeat (r) begin
					#16 o_image_clock = 1'b1;
					#16 o_image_clock = 1'b0;
				end
			end
			o_image_data = ~o_image_data;
		end
	endtask
	always @(posedge i_load_complete) begin
		if (user_en) begin
			#129;
			repeat (24) begin
				#16 o_user_init_clock = 1'b1;
				#16 o_user_init_clock = 1'b0;
			end
		end
	end
endmodule // ppl_host
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the configuration loader.
// Assumes ppl_host as far side and open-drain lines with pull-ups.
`timescale 1ns/1ps
`default_nettype none
`include "ppl_defs.vh"
module tb_top;
	logic clk, rst, wr, rd, rdy, hold_rdy, ext_low;
	logic [3:0] addr;
	logic [31:0] wdata, q;
	logic [15:0] base, mask, exp16;
	integer n_mismatch, checked, rx_idx;
	wire logic [31:0] rd_data;
	wire logic st_o, st_oe_n, cd_o, cd_oe_n, vld, user_mode, req_n, image_clock, uclk;
	wire logic [15:0] ddata, wdat;
	// Bench can pull the status line low like a second open-drain driver
	wire logic status_w = (st_oe_n ? 1'b1 : st_o) & ~ext_low;
	wire logic complete_w = cd_oe_n ? 1'b1 : cd_o;
	ppl_loader #(.P_POR_FAST_CYC(10), .P_POR_STD_CYC(20), .P_STATUS_MIN_CYC(16),
		.P_INIT_OSC_CYC(16), .P_INIT_USER_CYC(8)) i_dut (
		.i_clock(clk), .i_rst(rst), .i_addr(addr), .i_wr_data(wdata), .i_wr(wr),
		.i_rd(rd), .o_rd_data(rd_data), .i_reconfig_request_n(req_n),
		.i_image_clock(image_clock), .i_image_data(ddata), .i_user_init_clock(uclk),
		.i_load_status_n(status_w), .o_load_status_n(st_o), .o_load_status_n_oe_n(st_oe_n),
		.i_load_complete(complete_w), .o_load_complete(cd_o), .o_load_complete_oe_n(cd_oe_n),
		.o_word_valid(vld), .i_word_ready(rdy), .o_word_data(wdat), .o_user_mode(user_mode));
	ppl_host i_host (.i_load_status_n(status_w), .i_load_complete(complete_w),
		.o_reconfig_request_n(req_n), .o_image_clock(image_clock), .o_image_data(ddata),
		.o_user_init_clock(uclk));
	always #2 clk = ~clk;
	////////////////////////////////////////
	task check(input [31:0] seen, input [31:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task acc(input w, input [3:0] a, input [31:0] v);
		begin
			@(posedge clk);
			addr <= a;
			wdata <= v;
			wr <= w;
			rd <= !w;
			@(posedge clk);
			wr <= 1'b0;
			rd <= 1'b0;
			#1 q = rd_data;
		end
	endtask
	function [2:0] ratio(input [4:0] c);
		ratio = c[2] ? (c[0] ? 3'h4 : 3'h2) : ((c[0] && c[1]) ? 3'h2 : 3'h1);
	endfunction
	// Receiver stalls every other cycle, or every cycle while hold_rdy is set
	always @(posedge clk) begin
		rdy <= !hold_rdy && !rdy;
		if (vld && rdy) begin
			exp16 = base + rx_idx * 16'h1111;
			check(wdat, exp16 & mask);
			rx_idx = rx_idx + 1;
		end
	end
	////////////////////////////////////////
	task t_regs;
		begin
			acc(1'b0, `PPL_REG_CTRL, 32'h0);
			check(q, 32'h0);
			acc(1'b0, 4'h2, 32'h0);
			check(q, 32'h0);
		end
	endtask
	task t_ratio;
		integer i;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				acc(1'b1, `PPL_REG_CTRL, i);
				acc(1'b0, `PPL_REG_STATUS, 32'h0);
				check(q[9:7], ratio(i[4:0]));
			end
		end
	endtask
	task t_por(input f);
		integer n;
		begin
			rst <= 1'b1;
			repeat (16) @(posedge clk);
			rst <= 1'b0;
			acc(1'b1, `PPL_REG_CTRL, {27'h0, f, 4'h0});
			n = 0;
			while (status_w !== 1'b1 && n < 100) begin
				@(posedge clk);
				n = n + 1;
			end
			check(n > (f ? 20 : 32) && n < (f ? 30 : 42), 1'b1);
		end
	endtask
	task t_load(input [4:0] c, input integer n, input [15:0] b);
		integer w;
		begin
			acc(1'b1, `PPL_REG_CTRL, {27'h0, c});
			acc(1'b1, `PPL_REG_LEN, n);
			base = b;
			mask = c[0] ? 16'hffff : 16'h00ff;
			rx_idx = 0;
			i_host.user_en = c[3];
			i_host.request();
			check(complete_w, 1'b0);
			i_host.send(n, ratio(c), b);
			w = 0;
			while (user_mode !== 1'b1 && w < 2000) begin
				@(posedge clk);
				w = w + 1;
			end
			check(complete_w, 1'b1);
			check(user_mode, 1'b1);
			check(rx_idx, n);
			acc(1'b0, `PPL_REG_COUNT, 32'h0);
			check(q, n);
		end
	endtask
	// Status held low outside parks the load until the line is let go
	task t_hold;
		begin
			ext_low <= 1'b1;
			i_host.request();
			repeat (100) @(posedge clk);
			check(status_w, 1'b0);
			acc(1'b0, `PPL_REG_STATUS, 32'h0);
			check(q[6:0], 7'h04);
			ext_low <= 1'b0;
			repeat (8) @(posedge clk);
			check(status_w, 1'b1);
			acc(1'b0, `PPL_REG_STATUS, 32'h0);
			check(q[6:0], 7'h08);
		end
	endtask
	// Third word with both entries full must flag, the two held survive
	task t_ovf;
		begin
			hold_rdy <= 1'b1;
			acc(1'b1, `PPL_REG_CTRL, 32'h1);
			acc(1'b1, `PPL_REG_LEN, 32'h8);
			base = 16'h0f0f;
			mask = 16'hffff;
			rx_idx = 0;
			i_host.request();
			i_host.send(3, 1, 16'h0f0f);
			repeat (8) @(posedge clk);
			check(status_w, 1'b0);
			acc(1'b0, `PPL_REG_STATUS, 32'h0);
			check(q[10], 1'b1);
			hold_rdy <= 1'b0;
			repeat (8) @(posedge clk);
			check(rx_idx, 2);
		end
	endtask
	task report_and_stop;
		begin
			$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
			if (n_mismatch == 0 && checked > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	initial begin
		#200000;
		n_mismatch = n_mismatch + 1;
		report_and_stop;
	end
	initial begin
		{clk, wr, rd, rdy, hold_rdy, ext_low, addr, wdata, base, mask} = 0;
		{n_mismatch, checked, rx_idx} = 0;
		rst = 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_regs;
		t_ratio;
		t_por(1'b1);
		t_por(1'b0);
		t_load(5'h00, 4, 16'h1234);
		t_load(5'h0d, 3, 16'h4321);
		t_load(5'h03, 3, 16'h5a5a);
		t_load(5'h04, 2, 16'h00c3);
		t_hold;
		t_ovf;
		report_and_stop;
	end
endmodule // tb_top
`default_nettype wire
